// ---- logic/pfc_engine_pkg.sv ----
// Constants for the per-port priority flow control engine.
package pfc_engine_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PRIO_ENA_OFS = 8'h04;
  localparam logic [7:0] PAUSE_QUANTA_OFS = 8'h08;
  localparam logic [7:0] MIN_REFRESH_OFS = 8'h0C;
  localparam logic [7:0] WATERMARK_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] TX_PAUSE_FRAME_COUNT_OFS = 8'h18;
  localparam logic [7:0] RX_UNKNOWN_CNT_OFS = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TX_ENA_BIT = 0;
  localparam int CTRL_RX_ENA_BIT = 1;
  localparam int CTRL_TEN_GIG_BIT = 2;
  localparam int CTRL_SPEED_LSB = 4;
  localparam int STATUS_CONG_LSB = 0;
  localparam int STATUS_STOP_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] PRIO_ENA_RST = 8'hFF;
  localparam logic [15:0] PAUSE_QUANTA_RST = 16'hFFFF;
  localparam logic [15:0] MIN_REFRESH_RST = 16'h0010;
  localparam logic [11:0] WATERMARK_RST = 12'h800;

  // ----------------------------------------------------------------
  // Frame constants and widths
  // ----------------------------------------------------------------
  localparam int NUM_PRIO = 8;
  localparam int DEPTH_W = 12;
  localparam logic [15:0] PDU_PRIO_ENABLE_VEC = 16'h00FF;

  // ----------------------------------------------------------------
  // Link speed encodings and pause quantum durations
  // ----------------------------------------------------------------
  localparam logic [1:0] SPEED_10M = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1G = 2'h2;
  localparam logic [1:0] SPEED_10G = 2'h3;

  localparam longint CLK_PERIOD_PS = 25000;
  localparam longint QUANTUM_10M_PS = 51200000;
  localparam longint QUANTUM_100M_PS = 5120000;
  localparam longint QUANTUM_1G_PS = 512000;
  localparam longint QUANTUM_10G_PS = 51200;

  // A quantum is a longest pause, so cycle counts round down, never below one.
  localparam logic [11:0] Q10M_CYC = 12'(QUANTUM_10M_PS / CLK_PERIOD_PS - 1);
  localparam logic [11:0] Q100M_CYC = 12'(QUANTUM_100M_PS / CLK_PERIOD_PS - 1);
  localparam logic [11:0] Q1G_CYC = 12'(QUANTUM_1G_PS / CLK_PERIOD_PS - 1);
  localparam logic [11:0] Q10G_CYC = 12'(QUANTUM_10G_PS / CLK_PERIOD_PS - 1);

  // ----------------------------------------------------------------
  // Generation state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GEN_IDLE = 3'b001,
    GEN_SEND = 3'b010,
    GEN_WAIT = 3'b100
  } gen_state_e;

endpackage

// ---- logic/priority_flow_control_engine.sv ----
// Per-port priority flow control engine with APB register access.
`timescale 1ns/1ps
// Function
// - Flow control works for every priority of the port.
// - Pause transmission and pause reaction have separate enables.
// - Queue use above its watermark raises congestion for that priority.
// - Congestion is held as an eight-bit vector per port.
// - Pause quanta and minimum refresh interval are per-port settings.
// - A newly congested priority triggers a pause frame.
// - At half the advertised time, still congested priorities get a refresh frame.
// - Newly congested priorities during the timer use the minimum refresh interval.
// - One refresh timer serves all priorities of the port.
// - Every frame carries priority enable vector 0x00FF.
// - Disabled priorities always carry pause time zero.
// - Each sent pause frame, link-level ones too, bumps the transmit counter.
// - Ten-gig ports keep pause statistics themselves; otherwise this block does.
// - Received pause frames load the time of each priority set in their enable vector into a counter.
// - Received pause counters count down at the link-speed quantum rate.
// - A stop is signalled for each priority with a nonzero pause count.
// - Stop indications are held and gate the matching egress queues.
// - Pause reaction in the queue side needs the receive enable bit of CTRL set.
// - Received pause frames count in the unknown-opcode counter.
module priority_flow_control_engine (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [95:0] queue_depth,
  output logic pdu_tx_req,
  output logic [15:0] pdu_prio_enable,
  output logic [127:0] pdu_pause_time,
  input wire logic pdu_tx_ack,
  input wire logic link_pause_sent,
  input wire logic rx_pfc_valid,
  input wire logic [7:0] rx_pfc_prio_enable,
  input wire logic [127:0] rx_pfc_time,
  input wire logic [7:0] egress_queue_ready,
  output logic [7:0] egress_queue_grant,
  output logic [7:0] queue_stop
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [7:0] prio_ena_q;
  logic [15:0] pause_quanta_q;
  logic [15:0] min_refresh_interval_q;
  logic [11:0] watermark_q;
  logic [31:0] tx_pause_frame_count_q;
  logic [31:0] rx_unknown_opcode_count_q;
  logic [7:0] queue_congestion_vector_q;
  logic [7:0] stop_q;
  logic access;
  logic wr_en;
  logic mapped;

  logic tx_ena;
  logic rx_ena;
  logic ten_gig;
  logic [1:0] speed;

  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;
  assign tx_ena = ctrl_q[pfc_engine_pkg::CTRL_TX_ENA_BIT];
  assign rx_ena = ctrl_q[pfc_engine_pkg::CTRL_RX_ENA_BIT];
  assign ten_gig = ctrl_q[pfc_engine_pkg::CTRL_TEN_GIG_BIT];
  assign speed = ctrl_q[pfc_engine_pkg::CTRL_SPEED_LSB +: 2];

  always_comb begin
    unique case (paddr)
      pfc_engine_pkg::CTRL_OFS,
      pfc_engine_pkg::PRIO_ENA_OFS,
      pfc_engine_pkg::PAUSE_QUANTA_OFS,
      pfc_engine_pkg::MIN_REFRESH_OFS,
      pfc_engine_pkg::WATERMARK_OFS,
      pfc_engine_pkg::STATUS_OFS,
      pfc_engine_pkg::TX_PAUSE_FRAME_COUNT_OFS,
      pfc_engine_pkg::RX_UNKNOWN_CNT_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // The slave answers in the second access cycle, so pready is a flop.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= pfc_engine_pkg::CTRL_RST;
      prio_ena_q <= pfc_engine_pkg::PRIO_ENA_RST;
      pause_quanta_q <= pfc_engine_pkg::PAUSE_QUANTA_RST;
      min_refresh_interval_q <= pfc_engine_pkg::MIN_REFRESH_RST;
      watermark_q <= pfc_engine_pkg::WATERMARK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        pfc_engine_pkg::CTRL_OFS: begin
          ctrl_q <= {26'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
        end
        pfc_engine_pkg::PRIO_ENA_OFS: prio_ena_q <= pwdata[7:0];
        pfc_engine_pkg::PAUSE_QUANTA_OFS: pause_quanta_q <= pwdata[15:0];
        pfc_engine_pkg::MIN_REFRESH_OFS: min_refresh_interval_q <= pwdata[15:0];
        pfc_engine_pkg::WATERMARK_OFS: watermark_q <= pwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pslverr <= !mapped;
        unique case (paddr)
          pfc_engine_pkg::CTRL_OFS: prdata <= ctrl_q;
          pfc_engine_pkg::PRIO_ENA_OFS: prdata <= {24'h00_0000, prio_ena_q};
          pfc_engine_pkg::PAUSE_QUANTA_OFS: prdata <= {16'h0000, pause_quanta_q};
          pfc_engine_pkg::MIN_REFRESH_OFS: prdata <= {16'h0000, min_refresh_interval_q};
          pfc_engine_pkg::WATERMARK_OFS: prdata <= {20'h0_0000, watermark_q};
          pfc_engine_pkg::STATUS_OFS: begin
            prdata <= {16'h0000, stop_q, queue_congestion_vector_q};
          end
          pfc_engine_pkg::TX_PAUSE_FRAME_COUNT_OFS: prdata <= tx_pause_frame_count_q;
          pfc_engine_pkg::RX_UNKNOWN_CNT_OFS: prdata <= rx_unknown_opcode_count_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pause quantum tick
  // ----------------------------------------------------------------
  logic [11:0] tick_cnt_q;
  logic [11:0] tick_max;
  logic tick_q;

  always_comb begin
    unique case (speed)
      pfc_engine_pkg::SPEED_10M: tick_max = pfc_engine_pkg::Q10M_CYC;
      pfc_engine_pkg::SPEED_100M: tick_max = pfc_engine_pkg::Q100M_CYC;
      pfc_engine_pkg::SPEED_1G: tick_max = pfc_engine_pkg::Q1G_CYC;
      pfc_engine_pkg::SPEED_10G: tick_max = pfc_engine_pkg::Q10G_CYC;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= tick_max) begin
      tick_cnt_q <= 12'h000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Congestion tracking
  // ----------------------------------------------------------------
  logic [7:0] over_mark;

  generate
    for (genvar p = 0; p < pfc_engine_pkg::NUM_PRIO; p++) begin : g_mark
      assign over_mark[p] = queue_depth[p*pfc_engine_pkg::DEPTH_W +: pfc_engine_pkg::DEPTH_W]
                            > watermark_q;
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      queue_congestion_vector_q <= 8'h00;
    end else begin
      queue_congestion_vector_q <= over_mark;
    end
  end

  // ----------------------------------------------------------------
  // Pause frame generation
  // ----------------------------------------------------------------
  pfc_engine_pkg::gen_state_e gen_state_q;
  logic [16:0] elapsed_q;
  logic [7:0] sent_mask_q;
  logic [7:0] pdu_mask_q;
  logic [7:0] active_cong;
  logic new_cong;
  logic half_due;
  logic min_due;

  assign active_cong = queue_congestion_vector_q & prio_ena_q;
  assign new_cong = |(active_cong & ~sent_mask_q);
  assign half_due = elapsed_q >= {2'b00, pause_quanta_q[15:1]};
  assign min_due = elapsed_q >= {1'b0, min_refresh_interval_q};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gen_state_q <= pfc_engine_pkg::GEN_IDLE;
      elapsed_q <= 17'h0_0000;
      sent_mask_q <= 8'h00;
      pdu_tx_req <= 1'b0;
    end else begin
      unique case (gen_state_q)
        pfc_engine_pkg::GEN_IDLE: begin
          if (tx_ena && |active_cong) begin
            gen_state_q <= pfc_engine_pkg::GEN_SEND;
            pdu_tx_req <= 1'b1;
          end
        end
        pfc_engine_pkg::GEN_SEND: begin
          if (pdu_tx_ack) begin
            gen_state_q <= pfc_engine_pkg::GEN_WAIT;
            pdu_tx_req <= 1'b0;
            elapsed_q <= 17'h0_0000;
            sent_mask_q <= pdu_mask_q;
          end
        end
        pfc_engine_pkg::GEN_WAIT: begin
          if (tick_q) begin
            elapsed_q <= elapsed_q + 17'h0_0001;
          end
          if (!tx_ena || !(|active_cong)) begin
            gen_state_q <= pfc_engine_pkg::GEN_IDLE;
            sent_mask_q <= 8'h00;
          end else if (half_due || (new_cong && min_due)) begin
            gen_state_q <= pfc_engine_pkg::GEN_SEND;
            pdu_tx_req <= 1'b1;
          end
        end
        default: begin
          gen_state_q <= pfc_engine_pkg::GEN_IDLE;
          pdu_tx_req <= 1'b0;
        end
      endcase
    end
  end

  // Frame contents are frozen while the request is pending.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pdu_mask_q <= 8'h00;
      pdu_pause_time <= 128'h0;
      pdu_prio_enable <= 16'h0000;
    end else if (!pdu_tx_req) begin
      pdu_mask_q <= active_cong;
      pdu_prio_enable <= pfc_engine_pkg::PDU_PRIO_ENABLE_VEC;
      for (int p = 0; p < pfc_engine_pkg::NUM_PRIO; p++) begin
        pdu_pause_time[p*16 +: 16] <= active_cong[p] ? pause_quanta_q : 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Statistics
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_pause_frame_count_q <= 32'h0000_0000;
    end else if (!ten_gig) begin
      tx_pause_frame_count_q <= tx_pause_frame_count_q
                                + {31'h0, pdu_tx_ack && pdu_tx_req}
                                + {31'h0, link_pause_sent};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_unknown_opcode_count_q <= 32'h0000_0000;
    end else if (!ten_gig && rx_pfc_valid) begin
      rx_unknown_opcode_count_q <= rx_unknown_opcode_count_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Pause reception
  // ----------------------------------------------------------------
  logic [7:0] stop_d;

  generate
    for (genvar p = 0; p < pfc_engine_pkg::NUM_PRIO; p++) begin : g_rx
      logic [15:0] remain_q;

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          remain_q <= 16'h0000;
        end else if (rx_ena && rx_pfc_valid && rx_pfc_prio_enable[p]) begin
          remain_q <= rx_pfc_time[p*16 +: 16];
        end else if (tick_q && remain_q != 16'h0000) begin
          remain_q <= remain_q - 16'h0001;
        end
      end

      assign stop_d[p] = remain_q != 16'h0000;
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stop_q <= 8'h00;
      queue_stop <= 8'h00;
      egress_queue_grant <= 8'h00;
    end else begin
      stop_q <= stop_d;
      queue_stop <= stop_d;
      egress_queue_grant <= egress_queue_ready & ~stop_d;
    end
  end

endmodule

// ---- sim/pfc_engine_chk.sv ----
// Port checker for the priority flow control engine.
`timescale 1ns/1ps
module pfc_engine_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pdu_tx_req,
  input wire logic [15:0] pdu_prio_enable,
  input wire logic [127:0] pdu_pause_time,
  input wire logic pdu_tx_ack,
  input wire logic rx_pfc_valid,
  input wire logic [7:0] egress_queue_ready,
  input wire logic [7:0] egress_queue_grant,
  input wire logic [7:0] queue_stop
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_en_vec;
    pdu_tx_req |-> pdu_prio_enable == 16'h00FF;
  endproperty
  a_en_vec: assert property (p_en_vec)
    else $error("priority enable vector is not all eight bits");
  property p_req_hold;
    pdu_tx_req && !pdu_tx_ack |=> pdu_tx_req;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("frame request dropped before acknowledge");
  property p_fields;
    pdu_tx_req && !pdu_tx_ack |=> $stable(pdu_pause_time);
  endproperty
  a_fields: assert property (p_fields)
    else $error("pause times changed while a frame is pending");
  property p_ack_drop;
    pdu_tx_req && pdu_tx_ack |=> !pdu_tx_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("frame request stays after acknowledge");
  property p_stop_src;
    |(queue_stop & ~$past(queue_stop)) |-> $past(rx_pfc_valid, 2);
  endproperty
  a_stop_src: assert property (p_stop_src)
    else $error("stop rose without a received frame two cycles before");
  property p_grant;
    $past(rst_n) |-> egress_queue_grant == ($past(egress_queue_ready) & ~queue_stop);
  endproperty
  a_grant: assert property (p_grant)
    else $error("egress grant does not follow ready and stop");
  property p_pready;
    pready |=> !pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("ready held longer than one cycle");
  property p_slverr;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error response without ready or with data");

  c_frame: cover property (pdu_tx_req && pdu_tx_ack);
  c_stop: cover property (|queue_stop);
  c_err: cover property (pslverr);
endmodule

bind priority_flow_control_engine pfc_engine_chk u_pfc_engine_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pdu_tx_req(pdu_tx_req), .pdu_prio_enable(pdu_prio_enable),
  .pdu_pause_time(pdu_pause_time), .pdu_tx_ack(pdu_tx_ack), .rx_pfc_valid(rx_pfc_valid),
  .egress_queue_ready(egress_queue_ready), .egress_queue_grant(egress_queue_grant),
  .queue_stop(queue_stop)
);

// ---- sim/pfc_link_peer.sv ----
// Link partner model that acknowledges and sends pause frames.
`timescale 1ns/1ps
module pfc_link_peer (
  input wire logic ref_clk,
  input wire logic pdu_tx_req,
  input wire logic [127:0] pdu_pause_time,
  output logic pdu_tx_ack,
  output logic link_pause_sent,
  output logic rx_pfc_valid,
  output logic [7:0] rx_pfc_prio_enable,
  output logic [127:0] rx_pfc_time
);
  int ack_delay = 0;
  int n_ack = 0;
  int wait_q = 0;
  logic [7:0] held_q = 8'h00;

  initial begin
    pdu_tx_ack = 1'b0;
    link_pause_sent = 1'b0;
    rx_pfc_valid = 1'b0;
    rx_pfc_prio_enable = 8'h00;
    rx_pfc_time = '0;
  end

  always @(posedge ref_clk) begin
    pdu_tx_ack <= 1'b0;
    if (pdu_tx_req && !pdu_tx_ack) begin
      if (wait_q < ack_delay) begin
        wait_q <= wait_q + 1;
      end else begin
        pdu_tx_ack <= 1'b1;
        wait_q <= 0;
        n_ack <= n_ack + 1;
        for (int p = 0; p < 8; p++) held_q[p] <= pdu_pause_time[p*16+:16] != 16'h0000;
      end
    end
  end

  task automatic send_pfc(input logic [7:0] en, input logic [127:0] t);
    @(posedge ref_clk);
    rx_pfc_valid <= 1'b1;
    rx_pfc_prio_enable <= en;
    rx_pfc_time <= t;
    @(posedge ref_clk);
    rx_pfc_valid <= 1'b0;
    rx_pfc_prio_enable <= ~en;
    rx_pfc_time <= ~t;
  endtask

  task automatic link_pause();
    @(posedge ref_clk);
    link_pause_sent <= 1'b1;
    @(posedge ref_clk);
    link_pause_sent <= 1'b0;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the priority flow control engine.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdq;
  logic pready, pslverr, err_q;
  logic [95:0] queue_depth = '0;
  logic pdu_tx_req, pdu_tx_ack, link_pause_sent, rx_pfc_valid;
  logic [15:0] pdu_prio_enable;
  logic [127:0] pdu_pause_time, rx_pfc_time;
  logic [7:0] rx_pfc_prio_enable, queue_stop, egress_queue_grant;
  logic [7:0] egress_queue_ready = 8'hFF;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  priority_flow_control_engine u_priority_flow_control_engine (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .queue_depth(queue_depth), .pdu_tx_req(pdu_tx_req), .pdu_prio_enable(pdu_prio_enable),
    .pdu_pause_time(pdu_pause_time), .pdu_tx_ack(pdu_tx_ack),
    .link_pause_sent(link_pause_sent), .rx_pfc_valid(rx_pfc_valid),
    .rx_pfc_prio_enable(rx_pfc_prio_enable), .rx_pfc_time(rx_pfc_time),
    .egress_queue_ready(egress_queue_ready), .egress_queue_grant(egress_queue_grant),
    .queue_stop(queue_stop));
  pfc_link_peer u_pfc_link_peer (
    .ref_clk(ref_clk), .pdu_tx_req(pdu_tx_req), .pdu_pause_time(pdu_pause_time),
    .pdu_tx_ack(pdu_tx_ack), .link_pause_sent(link_pause_sent),
    .rx_pfc_valid(rx_pfc_valid), .rx_pfc_prio_enable(rx_pfc_prio_enable),
    .rx_pfc_time(rx_pfc_time));

  task automatic test_done();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdq = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_fail++;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(128'(rdq), 128'(e));
  endtask

  // Depth 0x801 is just above the default watermark, 0x800 just at it.
  task automatic cong(input logic [7:0] m);
    for (int p = 0; p < 8; p++) queue_depth[p*12+:12] <= m[p] ? 12'h801 : 12'h800;
  endtask

  task automatic wait_req(input int lim);
    int n;
    n = 0;
    while (pdu_tx_req !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk(128'(pdu_tx_req), 128'h1);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (pdu_tx_req === 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hFF);
    rd(8'h08, 32'hFFFF);
    rd(8'h0C, 32'h10);
    rd(8'h10, 32'h800);
    rd(8'h20, 32'h0);
    chk(128'(err_q), 128'h1);
    wr(8'h18, 32'h5);
    rd(8'h18, 32'h0);
    wr(8'h08, 32'h20);
    wr(8'h0C, 32'h2);
    wr(8'h04, 32'h7F);
    wr(8'h00, 32'h31);
    u_pfc_link_peer.ack_delay = 3;
    cong(8'h81);
    wait_req(20);
    chk(128'(pdu_prio_enable), 128'h00FF);
    chk(pdu_pause_time, 128'h20);
    rd(8'h14, 32'h81);
    wait_done();
    chk(128'(u_pfc_link_peer.held_q), 128'h01);
    u_pfc_link_peer.ack_delay = 0;
    wait_req(80);
    chk(pdu_pause_time, 128'h20);
    wait_done();
    cong(8'h89);
    wait_req(16);
    chk(pdu_pause_time, {64'h0, 16'h20, 32'h0, 16'h20});
    wait_done();
    cong(8'h00);
    tick(40);
    chk(128'(pdu_tx_req), 128'h0);
    rd(8'h18, 32'(u_pfc_link_peer.n_ack));
    u_pfc_link_peer.link_pause();
    tick(2);
    rd(8'h18, 32'(u_pfc_link_peer.n_ack + 1));
    wr(8'h00, 32'h35);
    u_pfc_link_peer.link_pause();
    tick(2);
    rd(8'h18, 32'(u_pfc_link_peer.n_ack + 1));
    wr(8'h00, 32'h32);
    cong(8'h01);
    tick(30);
    chk(128'(pdu_tx_req), 128'h0);
    rd(8'h14, 32'h01);
    u_pfc_link_peer.send_pfc(8'h05, 128'h0010_0000_0003);
    tick(3);
    chk(128'(queue_stop), 128'h05);
    chk(128'(egress_queue_grant), 128'hFA);
    tick(20);
    chk(128'(queue_stop), 128'h04);
    rd(8'h1C, 32'h1);
    cong(8'h00);
    wr(8'h00, 32'h31);
    tick(40);
    u_pfc_link_peer.send_pfc(8'hFF, {8{16'h0040}});
    tick(3);
    chk(128'(queue_stop), 128'h00);
    rd(8'h1C, 32'h2);
    wr(8'h00, 32'h22);
    u_pfc_link_peer.send_pfc(8'h01, 128'h2);
    tick(14);
    chk(128'(queue_stop), 128'h01);
    tick(40);
    chk(128'(queue_stop), 128'h00);
    test_done();
  end
endmodule
